// ---- design/cspc_pkg.sv ----
package cspc_pkg;
	localparam logic [7:0] ADDR_PTR_LO  = 8'h82;
	localparam logic [7:0] ADDR_PTR_HI  = 8'h83;
	localparam logic [7:0] ADDR_PWR     = 8'h87;
	localparam logic [7:0] ADDR_FLAGS   = 8'hD0;
	localparam logic [7:0] ADDR_PRIMARY = 8'hE0;
	localparam logic [7:0] ADDR_SECOND  = 8'hF0;
	localparam logic [7:0] RESET_BYTE   = 8'h00;
	localparam int BIT_CY   = 7;
	localparam int BIT_AC   = 6;
	localparam int BIT_UF0  = 5;
	localparam int BIT_BSH  = 4;
	localparam int BIT_BSL  = 3;
	localparam int BIT_OV   = 2;
	localparam int BIT_UF1  = 1;
	localparam int BIT_PAR  = 0;
	localparam int BIT_STOP = 1;
	localparam int BIT_IDLE = 0;
	localparam logic [4:0] BANK_STRIDE = 5'h08;
	localparam logic [15:0] MUL_LIMIT  = 16'h00FF;
	localparam logic [15:0] RESTART_PC = 16'h0000;

	typedef enum logic [2:0] {OP_NONE, OP_ADD, OP_ADDC, OP_SUBB, OP_MUL, OP_DIV} cspc_op_type;
	typedef enum {PM_RUN, PM_IDLE, PM_STOP} cspc_pm_type;

	typedef struct packed {
		logic [7:0] ptr_lo;
		logic [7:0] ptr_hi;
		logic [7:0] flags;
		logic [7:0] primary;
		logic [7:0] second;
	} cspc_regs_type;

	typedef struct packed {
		cspc_regs_type regs;
		cspc_pm_type   pm;
	} cspc_state_type;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       bit_op;
		logic [2:0] bit_pos;
		logic       bit_val;
	} cspc_sfr_req_type;

	typedef struct packed {
		cspc_op_type op;
		logic [7:0]  a;
		logic [7:0]  b;
		logic        cin;
	} cspc_alu_req_type;
endpackage

// ---- design/cspc_core.sv ----
`timescale 1ns/100ps
// Summary of operation
// (RULE1) Two pointer bytes form a 16-bit external pointer, both reset to zero.
// (RULE2) Carry flag set on add carry or subtract borrow, else cleared by arithmetic.
// (RULE3) Half carry set on nibble carry or borrow, else cleared by arithmetic.
// (RULE4) Flag bits 5 and 1 are plain software flags.
// (RULE5) Bank select bits pick register bank base 0x00, 0x08, 0x10 or 0x18.
// (RULE6) Signed overflow of add, add-with-carry or subtract sets overflow flag.
// (RULE7) Multiply product above 255 sets overflow flag.
// (RULE8) Divide by zero sets overflow flag.
// (RULE9) These arithmetic operations clear overflow flag otherwise.
// (RULE10) Parity bit shows odd count of ones in the accumulator, read only.
// (RULE11) Writing idle bit halts the processor after the instruction; state kept.
// (RULE12) Enabled interrupt ends idle, resumes processor and services interrupt.
// (RULE13) Reset ends idle or stop and restarts fetch at address zero.
// (RULE14) Enabled watchdog keeps running in idle and may reset out of it.
// (RULE15) Writing stop bit stops oscillator, processor, peripherals, timers, interrupts.
// (RULE16) Stop ignores interrupts; only reset leaves it.
// (RULE17) Enabled lost clock monitor stays active in stop and forces reset.
// (RULE18) Stop and idle bits act on writing one, read zero; upper bits reserved.
// (RULE19) Software sets the reference tempco enable before oscillator suspend.
// (RULE20) Accumulator and second operand registers, bit addressable, reset to zero.
// (RULE21) Writing both stop and idle together enters stop.
module cspc_core
(
	// Clock and reset
	input  wire logic                      mclk_i,
	input  wire logic                      reset_i,
	// Special register access
	input  wire cspc_pkg::cspc_sfr_req_type sfr_i,
	output logic [7:0]                     sfr_rdata_o,
	output logic                           sfr_hit_o,
	// Arithmetic result reporting
	input  wire cspc_pkg::cspc_alu_req_type alu_i,
	// Power management
	input  wire logic                      irq_pending_i,
	output logic                           cpu_halt_o,
	output logic                           osc_stop_o,
	output logic                           periph_clk_en_o,
	output logic [15:0]                    restart_pc_o,
	// Core views
	output logic [15:0]                    ext_pointer16_o,
	output logic [4:0]                     bank_base_o,
	output logic                           carry_o
);
	cspc_pkg::cspc_state_type state;
	cspc_pkg::cspc_state_type next_state;
	logic [8:0]  sum_full;
	logic [4:0]  sum_nib;
	logic [15:0] product;
	logic        odd_ones;
	logic [7:0]  flag_view;
	logic [7:0]  cur;
	logic [7:0]  merged;

	assign odd_ones = ^state.regs.primary; // RULE10

	always_comb
	begin
		flag_view = state.regs.flags;
		flag_view[cspc_pkg::BIT_PAR] = odd_ones; // RULE10
		sum_full = 9'h000;
		sum_nib = 5'h00;
		product = 16'h0000;
		cur = 8'h00;
		merged = 8'h00;
		next_state = state;
		// Software writes, byte or single bit
		case (sfr_i.addr)
			cspc_pkg::ADDR_PTR_LO: cur = state.regs.ptr_lo;
			cspc_pkg::ADDR_PTR_HI: cur = state.regs.ptr_hi;
			cspc_pkg::ADDR_FLAGS: cur = flag_view;
			cspc_pkg::ADDR_PRIMARY: cur = state.regs.primary;
			cspc_pkg::ADDR_SECOND: cur = state.regs.second;
			default: cur = 8'h00;
		endcase
		merged = sfr_i.wdata;
		if (sfr_i.bit_op)
		begin
			merged = cur;
			merged[sfr_i.bit_pos] = sfr_i.bit_val;
		end
		if (sfr_i.wr && state.pm == cspc_pkg::PM_RUN)
		begin
			case (sfr_i.addr)
				cspc_pkg::ADDR_PTR_LO: next_state.regs.ptr_lo = merged; // RULE1
				cspc_pkg::ADDR_PTR_HI: next_state.regs.ptr_hi = merged; // RULE1
				cspc_pkg::ADDR_FLAGS: next_state.regs.flags = merged; // RULE4
				cspc_pkg::ADDR_PRIMARY: next_state.regs.primary = merged; // RULE20
				cspc_pkg::ADDR_SECOND: next_state.regs.second = merged; // RULE20
				cspc_pkg::ADDR_PWR:
				begin
					if (merged[cspc_pkg::BIT_STOP])
						next_state.pm = cspc_pkg::PM_STOP; // RULE15 RULE21
					else if (merged[cspc_pkg::BIT_IDLE])
						next_state.pm = cspc_pkg::PM_IDLE; // RULE11
				end
				default: ;
			endcase
		end
		// Arithmetic flag updates
		if (state.pm == cspc_pkg::PM_RUN)
		begin
			case (alu_i.op)
				cspc_pkg::OP_ADD, cspc_pkg::OP_ADDC:
				begin
					sum_full = {1'b0, alu_i.a} + {1'b0, alu_i.b}
						+ {8'h00, alu_i.op == cspc_pkg::OP_ADDC && alu_i.cin};
					sum_nib = {1'b0, alu_i.a[3:0]} + {1'b0, alu_i.b[3:0]}
						+ {4'h0, alu_i.op == cspc_pkg::OP_ADDC && alu_i.cin};
					next_state.regs.flags[cspc_pkg::BIT_CY] = sum_full[8]; // RULE2
					next_state.regs.flags[cspc_pkg::BIT_AC] = sum_nib[4]; // RULE3
					next_state.regs.flags[cspc_pkg::BIT_OV] = (alu_i.a[7] == alu_i.b[7])
						&& (sum_full[7] != alu_i.a[7]); // RULE6 RULE9
				end
				cspc_pkg::OP_SUBB:
				begin
					sum_full = {1'b0, alu_i.a} - {1'b0, alu_i.b} - {8'h00, alu_i.cin};
					sum_nib = {1'b0, alu_i.a[3:0]} - {1'b0, alu_i.b[3:0]} - {4'h0, alu_i.cin};
					next_state.regs.flags[cspc_pkg::BIT_CY] = sum_full[8]; // RULE2
					next_state.regs.flags[cspc_pkg::BIT_AC] = sum_nib[4]; // RULE3
					next_state.regs.flags[cspc_pkg::BIT_OV] = (alu_i.a[7] != alu_i.b[7])
						&& (sum_full[7] != alu_i.a[7]); // RULE6 RULE9
				end
				cspc_pkg::OP_MUL:
				begin
					product = {8'h00, alu_i.a} * {8'h00, alu_i.b};
					next_state.regs.flags[cspc_pkg::BIT_CY] = 1'b0; // RULE2
					next_state.regs.flags[cspc_pkg::BIT_AC] = 1'b0; // RULE3
					next_state.regs.flags[cspc_pkg::BIT_OV] = product > cspc_pkg::MUL_LIMIT; // RULE7 RULE9
				end
				cspc_pkg::OP_DIV:
				begin
					next_state.regs.flags[cspc_pkg::BIT_CY] = 1'b0; // RULE2
					next_state.regs.flags[cspc_pkg::BIT_AC] = 1'b0; // RULE3
					next_state.regs.flags[cspc_pkg::BIT_OV] = alu_i.b == 8'h00; // RULE8 RULE9
				end
				default: ;
			endcase
		end
		// Interrupt wakes idle only, never stop
		if (state.pm == cspc_pkg::PM_IDLE && irq_pending_i)
			next_state.pm = cspc_pkg::PM_RUN; // RULE12 RULE16
		next_state.regs.flags[cspc_pkg::BIT_PAR] = 1'b0;
	end

	always_ff @(posedge mclk_i or posedge reset_i)
	begin
		if (reset_i)
			state <= '{regs: '{default: cspc_pkg::RESET_BYTE}, pm: cspc_pkg::PM_RUN}; // RULE13 RULE14 RULE17
		else
			state <= next_state;
	end

	always_comb
	begin
		sfr_hit_o = 1'b1;
		case (sfr_i.addr)
			cspc_pkg::ADDR_PTR_LO: sfr_rdata_o = state.regs.ptr_lo;
			cspc_pkg::ADDR_PTR_HI: sfr_rdata_o = state.regs.ptr_hi;
			cspc_pkg::ADDR_PWR: sfr_rdata_o = 8'h00; // RULE18
			cspc_pkg::ADDR_FLAGS: sfr_rdata_o = flag_view;
			cspc_pkg::ADDR_PRIMARY: sfr_rdata_o = state.regs.primary;
			cspc_pkg::ADDR_SECOND: sfr_rdata_o = state.regs.second;
			default:
			begin
				sfr_rdata_o = 8'h00;
				sfr_hit_o = 1'b0;
			end
		endcase
	end

	assign cpu_halt_o = state.pm != cspc_pkg::PM_RUN; // RULE11 RULE15
	assign osc_stop_o = state.pm == cspc_pkg::PM_STOP; // RULE15
	assign periph_clk_en_o = state.pm != cspc_pkg::PM_STOP; // RULE11 RULE15
	assign restart_pc_o = cspc_pkg::RESTART_PC; // RULE13
	assign ext_pointer16_o = {state.regs.ptr_hi, state.regs.ptr_lo}; // RULE1
	assign bank_base_o = 5'({state.regs.flags[cspc_pkg::BIT_BSH], state.regs.flags[cspc_pkg::BIT_BSL]})
		* cspc_pkg::BANK_STRIDE; // RULE5
	assign carry_o = state.regs.flags[cspc_pkg::BIT_CY];

	property p_stop_sticky;
		@(posedge mclk_i) disable iff (reset_i)
		osc_stop_o |=> osc_stop_o;
	endproperty
	a_stop_sticky: assert property (p_stop_sticky) else $error("stop left without reset"); // RULE16

	property p_idle_wake;
		@(posedge mclk_i) disable iff (reset_i)
		(state.pm == cspc_pkg::PM_IDLE && irq_pending_i) |=> !cpu_halt_o;
	endproperty
	a_idle_wake: assert property (p_idle_wake) else $error("idle not ended by interrupt"); // RULE12

	property p_stop_prio;
		@(posedge mclk_i) disable iff (reset_i)
		(!cpu_halt_o && sfr_i.wr && !sfr_i.bit_op && sfr_i.addr == cspc_pkg::ADDR_PWR
			&& sfr_i.wdata[cspc_pkg::BIT_STOP]) |=> osc_stop_o;
	endproperty
	a_stop_prio: assert property (p_stop_prio) else $error("stop write ignored"); // RULE15 RULE21

	property p_idle_enter;
		@(posedge mclk_i) disable iff (reset_i)
		(!cpu_halt_o && sfr_i.wr && !sfr_i.bit_op && sfr_i.addr == cspc_pkg::ADDR_PWR
			&& sfr_i.wdata[1:0] == 2'b01) |=> (cpu_halt_o && !osc_stop_o);
	endproperty
	a_idle_enter: assert property (p_idle_enter) else $error("idle not entered"); // RULE11

	property p_pwr_reads_zero;
		@(posedge mclk_i) disable iff (reset_i)
		sfr_i.addr == cspc_pkg::ADDR_PWR |-> sfr_rdata_o == 8'h00;
	endproperty
	a_pwr_reads_zero: assert property (p_pwr_reads_zero) else $error("power reg not zero"); // RULE18

	property p_parity;
		@(posedge mclk_i) disable iff (reset_i)
		sfr_i.addr == cspc_pkg::ADDR_FLAGS |-> sfr_rdata_o[0] == ^state.regs.primary;
	endproperty
	a_parity: assert property (p_parity) else $error("parity wrong"); // RULE10

	property p_div_zero;
		@(posedge mclk_i) disable iff (reset_i)
		(!cpu_halt_o && alu_i.op == cspc_pkg::OP_DIV)
			|=> state.regs.flags[cspc_pkg::BIT_OV] == ($past(alu_i.b) == 8'h00);
	endproperty
	a_div_zero: assert property (p_div_zero) else $error("divide overflow wrong"); // RULE8

	property p_mul_ov;
		@(posedge mclk_i) disable iff (reset_i)
		(!cpu_halt_o && alu_i.op == cspc_pkg::OP_MUL)
			|=> state.regs.flags[cspc_pkg::BIT_OV] == ($past(alu_i.a) * $past(alu_i.b) > cspc_pkg::MUL_LIMIT);
	endproperty
	a_mul_ov: assert property (p_mul_ov) else $error("multiply overflow wrong"); // RULE7

	property p_add_carry;
		@(posedge mclk_i) disable iff (reset_i)
		(!cpu_halt_o && alu_i.op == cspc_pkg::OP_ADD) |=> carry_o == ({1'b0, $past(alu_i.a)} + {1'b0, $past(alu_i.b)} > 9'h0FF);
	endproperty
	a_add_carry: assert property (p_add_carry) else $error("add carry wrong"); // RULE2

	property p_ptr_lo_write;
		@(posedge mclk_i) disable iff (reset_i)
		(!cpu_halt_o && sfr_i.wr && !sfr_i.bit_op && sfr_i.addr == cspc_pkg::ADDR_PTR_LO)
			|=> ext_pointer16_o[7:0] == $past(sfr_i.wdata);
	endproperty
	a_ptr_lo_write: assert property (p_ptr_lo_write) else $error("pointer low write lost"); // RULE1

	property p_ptr_hi_write;
		@(posedge mclk_i) disable iff (reset_i)
		(!cpu_halt_o && sfr_i.wr && !sfr_i.bit_op && sfr_i.addr == cspc_pkg::ADDR_PTR_HI)
			|=> ext_pointer16_o[15:8] == $past(sfr_i.wdata);
	endproperty
	a_ptr_hi_write: assert property (p_ptr_hi_write) else $error("pointer high write lost"); // RULE1

	property p_reset_clear;
		@(posedge mclk_i)
		$fell(reset_i) |-> (!cpu_halt_o && state.regs.primary == cspc_pkg::RESET_BYTE
			&& ext_pointer16_o == {cspc_pkg::RESET_BYTE, cspc_pkg::RESET_BYTE});
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("reset state wrong"); // RULE13

	property p_sub_borrow;
		@(posedge mclk_i) disable iff (reset_i)
		(!cpu_halt_o && alu_i.op == cspc_pkg::OP_SUBB) |=> carry_o == ({1'b0, $past(alu_i.a)}
			< ({1'b0, $past(alu_i.b)} + {8'h00, $past(alu_i.cin)}));
	endproperty
	a_sub_borrow: assert property (p_sub_borrow) else $error("subtract borrow wrong"); // RULE2

	property p_add_nibble;
		@(posedge mclk_i) disable iff (reset_i)
		(!cpu_halt_o && alu_i.op == cspc_pkg::OP_ADD) |=> state.regs.flags[cspc_pkg::BIT_AC]
			== ({1'b0, $past(alu_i.a[3:0])} + {1'b0, $past(alu_i.b[3:0])} > 5'h0F);
	endproperty
	a_add_nibble: assert property (p_add_nibble) else $error("half carry wrong"); // RULE3

	property p_muldiv_clear;
		@(posedge mclk_i) disable iff (reset_i)
		(!cpu_halt_o && (alu_i.op == cspc_pkg::OP_MUL || alu_i.op == cspc_pkg::OP_DIV))
			|=> (!carry_o && !state.regs.flags[cspc_pkg::BIT_AC]);
	endproperty
	a_muldiv_clear: assert property (p_muldiv_clear) else $error("carries not cleared"); // RULE2 RULE3

	property p_user_flags;
		@(posedge mclk_i) disable iff (reset_i)
		(!cpu_halt_o && sfr_i.wr && !sfr_i.bit_op && sfr_i.addr == cspc_pkg::ADDR_FLAGS)
			|=> (state.regs.flags[cspc_pkg::BIT_UF0] == $past(sfr_i.wdata[cspc_pkg::BIT_UF0])
			&& state.regs.flags[cspc_pkg::BIT_UF1] == $past(sfr_i.wdata[cspc_pkg::BIT_UF1]));
	endproperty
	a_user_flags: assert property (p_user_flags) else $error("user flag write lost"); // RULE4

	property p_bank_base;
		@(posedge mclk_i) disable iff (reset_i)
		bank_base_o == {state.regs.flags[cspc_pkg::BIT_BSH], state.regs.flags[cspc_pkg::BIT_BSL], 3'b000};
	endproperty
	a_bank_base: assert property (p_bank_base) else $error("bank base wrong"); // RULE5

	property p_add_ov_clear;
		@(posedge mclk_i) disable iff (reset_i)
		(!cpu_halt_o && alu_i.op == cspc_pkg::OP_ADD && alu_i.a[7] != alu_i.b[7])
			|=> !state.regs.flags[cspc_pkg::BIT_OV];
	endproperty
	a_add_ov_clear: assert property (p_add_ov_clear) else $error("overflow not cleared"); // RULE6 RULE9

	property p_halt_holds;
		@(posedge mclk_i) disable iff (reset_i)
		cpu_halt_o |=> $stable(state.regs);
	endproperty
	a_halt_holds: assert property (p_halt_holds) else $error("registers changed while halted"); // RULE11

	property p_idle_periph;
		@(posedge mclk_i) disable iff (reset_i)
		(cpu_halt_o && !osc_stop_o) |-> periph_clk_en_o;
	endproperty
	a_idle_periph: assert property (p_idle_periph) else $error("peripherals stopped in idle"); // RULE11

	property p_stop_outputs;
		@(posedge mclk_i) disable iff (reset_i)
		osc_stop_o |-> (cpu_halt_o && !periph_clk_en_o);
	endproperty
	a_stop_outputs: assert property (p_stop_outputs) else $error("stop outputs wrong"); // RULE15

	property p_stop_irq;
		@(posedge mclk_i) disable iff (reset_i)
		(osc_stop_o && irq_pending_i) |=> (osc_stop_o && cpu_halt_o);
	endproperty
	a_stop_irq: assert property (p_stop_irq) else $error("interrupt woke stop"); // RULE16

	property p_primary_write;
		@(posedge mclk_i) disable iff (reset_i)
		(!cpu_halt_o && sfr_i.wr && !sfr_i.bit_op && sfr_i.addr == cspc_pkg::ADDR_PRIMARY)
			|=> state.regs.primary == $past(sfr_i.wdata);
	endproperty
	a_primary_write: assert property (p_primary_write) else $error("accumulator write lost"); // RULE20

	property p_second_write;
		@(posedge mclk_i) disable iff (reset_i)
		(!cpu_halt_o && sfr_i.wr && !sfr_i.bit_op && sfr_i.addr == cspc_pkg::ADDR_SECOND)
			|=> state.regs.second == $past(sfr_i.wdata);
	endproperty
	a_second_write: assert property (p_second_write) else $error("second operand write lost"); // RULE20

	property p_bit_write;
		@(posedge mclk_i) disable iff (reset_i)
		(!cpu_halt_o && sfr_i.wr && sfr_i.bit_op && sfr_i.addr == cspc_pkg::ADDR_PRIMARY)
			|=> state.regs.primary[$past(sfr_i.bit_pos)] == $past(sfr_i.bit_val);
	endproperty
	a_bit_write: assert property (p_bit_write) else $error("bit write lost"); // RULE20

	property p_par_not_stored;
		@(posedge mclk_i) disable iff (reset_i)
		state.regs.flags[cspc_pkg::BIT_PAR] == 1'b0;
	endproperty
	a_par_not_stored: assert property (p_par_not_stored) else $error("parity bit stored"); // RULE10

	property p_unmapped_zero;
		@(posedge mclk_i) disable iff (reset_i)
		!sfr_hit_o |-> sfr_rdata_o == cspc_pkg::RESET_BYTE;
	endproperty
	a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero"); // RULE18
endmodule

// ---- dv/cspc_alu_model.sv ----
`timescale 1ns/100ps
// Instruction side: one arithmetic report per cycle, registered
module cspc_alu_model
(
	// Clock and reset
	input  wire logic                       mclk_i,
	input  wire logic                       reset_i,
	// Command in, report out
	input  wire cspc_pkg::cspc_alu_req_type cmd_i,
	output cspc_pkg::cspc_alu_req_type      alu_o
);
	always_ff @(posedge mclk_i or posedge reset_i)
		if (reset_i)
			alu_o <= '0;
		else
			alu_o <= cmd_i;
endmodule

// ---- dv/cspc_core_tb.sv ----
`timescale 1ns/100ps
`define CMP(n, e, g) begin checks++; if ((g) !== (e)) begin fail_count++; \
	$display("CHECK FAILED %s expected %h seen %h", n, e, g); end end
module cspc_core_tb;
	logic                       mclk_i = 1'b0;
	logic                       reset_i = 1'b1;
	logic                       irq = 1'b0;
	cspc_pkg::cspc_sfr_req_type sfr = '0;
	cspc_pkg::cspc_alu_req_type cmd = '0;
	cspc_pkg::cspc_alu_req_type alu;
	cspc_pkg::cspc_op_type      o;
	logic [7:0]                 rdata, a, b;
	logic                       halt, ostop, pclk, carry, c, hit;
	logic [15:0]                rpc;
	logic [4:0]                 bank;
	logic [15:0]                ptr16;
	logic [33:0]                exp_v;
	logic [33:0]                q[$];
	logic [31:0]                lfsr = 32'hCA7C;
	logic [7:0]                 mv[6] = '{default: 8'h00};
	logic [7:0]                 addrs[6] = '{8'h82, 8'h83, 8'h87, 8'hD0, 8'hE0, 8'hF0};
	logic [2:0]                 pm = 3'b001;
	int                         fail_count = 0;
	int                         checks = 0;

	always #5 mclk_i = ~mclk_i;

	cspc_alu_model cspc_alu_model_inst (.mclk_i(mclk_i), .reset_i(reset_i), .cmd_i(cmd), .alu_o(alu));
	cspc_core cspc_core_inst (.mclk_i(mclk_i), .reset_i(reset_i), .sfr_i(sfr), .sfr_rdata_o(rdata),
		.sfr_hit_o(hit), .alu_i(alu), .irq_pending_i(irq), .cpu_halt_o(halt), .osc_stop_o(ostop),
		.periph_clk_en_o(pclk), .restart_pc_o(rpc), .ext_pointer16_o(ptr16), .bank_base_o(bank),
		.carry_o(carry));

	// Output watcher
	always @(posedge mclk_i)
		if (sfr.rd)
		begin
			exp_v = q.pop_front();
			`CMP($sformatf("reg %h", sfr.addr), exp_v, {hit, halt, ostop, pclk, carry, bank, ptr16, rdata})
			`CMP("restart pc", cspc_pkg::RESTART_PC, rpc)
		end

	function automatic logic [7:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr[7:0];
	endfunction

	function automatic logic [7:0] rv(input int k);
		return (k == 3) ? {mv[3][7:1], ^mv[4]} : mv[k];
	endfunction

	function automatic logic [33:0] ex(input logic [7:0] d);
		return {1'b1, pm, mv[3][7], mv[3][4:3], 3'b000, mv[1], mv[0], d};
	endfunction

	function automatic logic [2:0] flg(input cspc_pkg::cspc_op_type p, input logic [7:0] x, y, input logic ci);
		logic [8:0] s = x + y + ci;
		logic [8:0] d = x - y - ci;
		logic [4:0] hs = x[3:0] + y[3:0] + ci;
		logic [4:0] hd = x[3:0] - y[3:0] - ci;
		if (p == cspc_pkg::OP_ADD || p == cspc_pkg::OP_ADDC)
			return {s[8], hs[4], (x[7] == y[7]) && (s[7] != x[7])};
		if (p == cspc_pkg::OP_SUBB)
			return {d[8], hd[4], (x[7] != y[7]) && (d[7] != x[7])};
		if (p == cspc_pkg::OP_MUL)
			return {2'b00, x * y > 16'h00FF};
		return {2'b00, y == 8'h00};
	endfunction

	task automatic wr(input logic [7:0] ad, input logic [7:0] d, input logic bo, input logic [2:0] bp);
		@(posedge mclk_i);
		sfr <= '{wr: 1'b1, rd: 1'b0, addr: ad, wdata: d, bit_op: bo, bit_pos: bp, bit_val: d[0]};
		@(posedge mclk_i);
		sfr.wr <= 1'b0;
	endtask

	task automatic chk(input logic [7:0] ad, input logic [33:0] e);
		@(posedge mclk_i);
		sfr <= '{wr: 1'b0, rd: 1'b1, addr: ad, wdata: 8'h00, bit_op: 1'b0, bit_pos: 3'h0, bit_val: 1'b0};
		q.push_back(e);
		@(posedge mclk_i);
		sfr.rd <= 1'b0;
	endtask

	task automatic chk_all();
		for (int k = 0; k < 6; k++)
			chk(addrs[k], ex(rv(k)));
	endtask

	task automatic pulse_irq();
		@(posedge mclk_i);
		irq <= 1'b1;
		@(posedge mclk_i);
		irq <= 1'b0;
	endtask

	task automatic wrap_up();
		if (fail_count == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	initial
	begin
		repeat (5) @(posedge mclk_i);
		reset_i <= 1'b0;
		chk_all();
		for (int k = 0; k < 6; k++)
			if (k != 2 && k != 3)
			begin
				mv[k] = rnd();
				wr(addrs[k], mv[k], 1'b0, 3'h0);
			end
		wr(8'h84, rnd(), 1'b0, 3'h0);
		chk_all();
		chk(8'h84, ex(8'h00) & 34'h1_FFFF_FFFF);
		for (int k = 0; k < 4; k++)
		begin
			mv[3] = {2'b00, k[0], k[1:0], 1'b0, k[1], 1'b0};
			wr(cspc_pkg::ADDR_FLAGS, mv[3] | 8'h01, 1'b0, 3'h0);
			chk(cspc_pkg::ADDR_FLAGS, ex(rv(3)));
		end
		wr(cspc_pkg::ADDR_FLAGS, 8'h01, 1'b1, 3'h5);
		mv[3][5] = 1'b1;
		wr(cspc_pkg::ADDR_PRIMARY, 8'h00, 1'b1, 3'h0);
		mv[4][0] = 1'b0;
		chk_all();
		for (int i = 0; i < 30; i++)
		begin
			o = cspc_pkg::cspc_op_type'(i % 5 + 1);
			a = rnd();
			b = (i < 5) ? 8'h00 : rnd();
			c = (o == cspc_pkg::OP_ADD) ? 1'b0 : lfsr[9];
			{mv[3][7], mv[3][6], mv[3][2]} = flg(o, a, b, c);
			@(posedge mclk_i);
			cmd <= '{op: o, a: a, b: b, cin: c};
			@(posedge mclk_i);
			cmd.op <= cspc_pkg::OP_NONE;
			chk(cspc_pkg::ADDR_FLAGS, ex(rv(3)));
		end
		wr(cspc_pkg::ADDR_PWR, 8'h01, 1'b0, 3'h0);
		pm = 3'b101;
		wr(cspc_pkg::ADDR_PRIMARY, 8'hA5, 1'b0, 3'h0);
		chk(cspc_pkg::ADDR_PWR, ex(8'h00));
		chk(cspc_pkg::ADDR_PRIMARY, ex(mv[4]));
		pulse_irq();
		pm = 3'b001;
		chk(cspc_pkg::ADDR_PRIMARY, ex(mv[4]));
		wr(cspc_pkg::ADDR_PWR, 8'h03, 1'b0, 3'h0);
		pm = 3'b110;
		pulse_irq();
		chk(cspc_pkg::ADDR_PWR, ex(8'h00));
		@(posedge mclk_i);
		reset_i <= 1'b1;
		@(posedge mclk_i);
		reset_i <= 1'b0;
		pm = 3'b001;
		mv = '{default: 8'h00};
		chk_all();
		wrap_up();
	end

	initial
	begin
		repeat (20000) @(posedge mclk_i);
		fail_count++;
		wrap_up();
	end
endmodule
